// *** bench/flash_array_model.sv ***
// Behavioural flash array for the far side of the sequencer
`timescale 1ns/1ps
module flash_array_model #(parameter int ADDR_W = 18, parameter int DATA_W = 16) (
	input wire logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] data
);
	// Word differs per low 16 address bits, so a stale address differing there cannot pass
	assign data = DATA_W'(addr) ^ DATA_W'(16'ha5c3);
endmodule : flash_array_model

// *** bench/flash_wait_chk.sv ***
// Port checker for the flash wait-state sequencer
`timescale 1ns/1ps
module flash_wait_chk #(parameter int DATA_W = 16, parameter int PROG_CYCLES = 10) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] flash_wait_state_field,
	input wire logic rd_req,
	input wire logic rd_seq,
	input wire logic rd_ready,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [DATA_W-1:0] array_data,
	input wire logic prog_start,
	input wire logic pe_busy,
	input wire logic pe_done
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// One cycle of slack on the end of the program timer
	localparam int P_LO = PROG_CYCLES - 1;
	localparam int P_HI = PROG_CYCLES;
	property p_seq; rd_req && rd_seq |-> ##1 !rd_ready ##1 rd_ready; endproperty
	a_seq: assert property (p_seq) else $error("seq read latency");
	property p_w0; rd_req && !rd_seq && flash_wait_state_field == 2'h0 |-> ##2 rd_ready; endproperty
	a_w0: assert property (p_w0) else $error("zero wait latency");
	property p_w1; rd_req && !rd_seq && flash_wait_state_field == 2'h1 |-> ##1 !rd_ready[*2] ##1 rd_ready; endproperty
	a_w1: assert property (p_w1) else $error("one wait latency");
	property p_w2; rd_req && !rd_seq && flash_wait_state_field[1] |-> ##1 !rd_ready[*3] ##1 rd_ready; endproperty
	a_w2: assert property (p_w2) else $error("two wait latency");
	property p_data; rd_ready |-> rd_data == $past(array_data); endproperty
	a_data: assert property (p_data) else $error("read data");
	property p_prog; prog_start && !pe_busy |=> pe_busy ##[P_LO:P_HI] pe_done; endproperty
	a_prog: assert property (p_prog) else $error("program time");
endmodule : flash_wait_chk
bind flash_wait_state_access flash_wait_chk #(.DATA_W(DATA_W), .PROG_CYCLES(PROG_CYCLES)) i_chk (.*);

// *** bench/tb.sv ***
// Self-checking bench for the flash wait-state sequencer
`timescale 1ns/1ps
module tb;
	logic ref_clk = 0, rst_n = 0, rd_req = 0, rd_seq = 0, prog_start = 0, erase_start = 0;
	logic [1:0] flash_wait_state_field = 2'h0;
	logic [17:0] rd_addr = 18'h0, array_addr;
	logic [15:0] rd_data, array_data;
	logic rd_ready, pe_busy, pe_done;
	int mismatches = 0, checks = 0, n;
	always #10 ref_clk = ~ref_clk;
	flash_wait_state_access #(.PROG_CYCLES(10), .ERASE_CYCLES(20)) i_dut (.*);
	flash_array_model i_arr (.addr(array_addr), .data(array_data));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (exp !== got) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	// Single read from idle; w is the expected wait count
	task rd(input logic [1:0] f, input logic s, input logic [17:0] a, input int w);
		@(posedge ref_clk);
		flash_wait_state_field <= f;
		rd_seq <= s;
		rd_addr <= a;
		rd_req <= 1'h1;
		@(posedge ref_clk);
		rd_req <= 1'h0;
		n = 0;
		do begin @(posedge ref_clk); #1; n++; end while (rd_ready !== 1'h1 && n < 9);
		chk("latency", 32'(w + 1), 32'(n));
		chk("rd_data", 32'(a[15:0] ^ 16'ha5c3), 32'(rd_data));
		chk("array_addr", 32'(a), 32'(array_addr));
		$display("read test done");
	endtask : rd
	// Program or erase; a second start while busy must be ignored
	task pe(input logic e, input int w);
		@(posedge ref_clk);
		prog_start <= !e;
		erase_start <= e;
		@(posedge ref_clk);
		prog_start <= 1'h0;
		erase_start <= 1'h1;
		#1 chk("pe_busy_on", 32'h1, 32'(pe_busy));
		n = 0;
		do begin @(posedge ref_clk); erase_start <= 1'h0; #1; n++; end while (pe_done !== 1'h1 && n < 99);
		chk("pe_done", 32'(w), 32'(n));
		chk("pe_busy", 32'h0, 32'(pe_busy));
		$display("program erase test done");
	endtask : pe
	task test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(2'h0, 1'h0, 18'h00011, 0);
		rd(2'h1, 1'h0, 18'h3fffe, 1);
		rd(2'h2, 1'h0, 18'h12345, 2);
		rd(2'h3, 1'h0, 18'h2aaaa, 2);
		rd(2'h2, 1'h1, 18'h00100, 0);
		pe(1'h0, 10);
		pe(1'h1, 20);
		test_done;
	end
	// Watchdog well past the sixty or so cycles the tests need
	initial begin
		repeat (2000) @(posedge ref_clk);
		mismatches++;
		test_done;
	end
endmodule : tb

// *** core/flash_wait_pkg.sv ***
// Types for the flash wait-state access controller
package flash_wait_pkg;
	// Read sequencer states
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_WAIT = 2'b01
	} rd_state_t;
	// Program/erase sequencer states
	typedef enum logic [1:0] {
		PE_IDLE = 2'b00,
		PE_PROG = 2'b01,
		PE_ERASE = 2'b10
	} pe_state_t;
endpackage : flash_wait_pkg

// *** core/flash_wait_regs.svh ***
// Constants for the flash wait-state access controller
`ifndef FLASH_WAIT_REGS_SVH
`define FLASH_WAIT_REGS_SVH
`define WAIT_FIELD_ZERO 2'h0
`define WAIT_FIELD_ONE 2'h1
`define WAIT_FIELD_TWO 2'h2
`define WAIT_FIELD_RSVD 2'h3
`define WAIT_FIELD_RESET 2'h3
`define CLK_MHZ 50
`define PROG_TIME_MS 5
`define ERASE_TIME_MS 500
`define PROG_CYCLES (`PROG_TIME_MS * 1000 * `CLK_MHZ)
`define ERASE_CYCLES (`ERASE_TIME_MS * 1000 * `CLK_MHZ)
`define PROG_BLOCK_BYTES 128
`endif

// *** core/flash_wait_state_access.sv ***
// Flash read wait-state sequencer with program and erase busy timing
`timescale 1ns/1ps
`include "flash_wait_regs.svh"
module flash_wait_state_access #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16,
	parameter int PROG_CYCLES = `PROG_CYCLES,
	parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] flash_wait_state_field,
	input wire logic rd_req,
	input wire logic rd_seq,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic rd_ready,
	output logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] array_addr,
	input wire logic [DATA_W-1:0] array_data,
	input wire logic prog_start,
	input wire logic erase_start,
	output logic pe_busy,
	output logic pe_done
);
	// Decode the field into a wait-state count; reserved code saturates.
	// Saturating rather than wrapping keeps a mis-set field on the safe,
	// slow side: the array always gets at least its longest documented time.
	function automatic logic [1:0] wait_state_count(input logic [1:0] f);
		case (f)
			`WAIT_FIELD_ZERO: wait_state_count = 2'h0;
			`WAIT_FIELD_ONE: wait_state_count = 2'h1;
			`WAIT_FIELD_TWO: wait_state_count = 2'h2;
			default: wait_state_count = 2'h2;
		endcase
	endfunction : wait_state_count

	// Read side state
	flash_wait_pkg::rd_state_t rd_state; // Read sequencer
	logic [1:0] wait_left; // Remaining wait cycles
	logic [1:0] next_wait_left; // Waits to load when a read is taken
	logic take_rd; // A read is accepted at this edge
	logic end_rd; // The running read completes at this edge

	// Program/erase side state
	flash_wait_pkg::pe_state_t pe_state; // Program/erase sequencer
	logic [31:0] pe_count; // Busy countdown
	logic take_prog; // A program start is accepted at this edge
	logic take_erase; // An erase start is accepted at this edge
	logic end_pe; // The running program or erase ends at this edge

	// Read acceptance and wait decode.
	// Requests are only looked at while idle; a request during a running
	// access is dropped without notice, so the fetch side must wait for
	// rd_ready before asking again.
	always_comb begin
		take_rd = 1'b0;
		next_wait_left = 2'h0;
		end_rd = 1'b0;
		// Idle: a request starts an access
		if (rd_state == flash_wait_pkg::RD_IDLE) begin
			take_rd = rd_req;
		end
		// Sequential fetches are treated as prefetch hits and skip the waits
		if (rd_seq) begin
			next_wait_left = 2'h0;
		end else begin
			next_wait_left = wait_state_count(flash_wait_state_field);
		end
		// Access phase over once no wait is left
		if (rd_state == flash_wait_pkg::RD_WAIT && wait_left == 2'h0) begin
			end_rd = 1'b1;
		end
	end

	// Read sequencer state: idle, then one access cycle plus the waits.
	// The field is sampled only when the read is taken, so a change of the
	// field in mid-access does not stretch or cut the running access.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_state <= flash_wait_pkg::RD_IDLE;
		end else begin
			case (rd_state)
				// Waiting for a fetch
				flash_wait_pkg::RD_IDLE: begin
					if (take_rd) begin
						rd_state <= flash_wait_pkg::RD_WAIT;
					end
				end
				// Access running
				flash_wait_pkg::RD_WAIT: begin
					if (end_rd) begin
						rd_state <= flash_wait_pkg::RD_IDLE;
					end
				end
				// Unused code: recover to idle
				default: begin
					rd_state <= flash_wait_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// Wait counter: loaded on take, counts down while the access runs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_left <= 2'h0;
		end else if (take_rd) begin
			// Load the waits for this access
			wait_left <= next_wait_left;
		end else if (rd_state == flash_wait_pkg::RD_WAIT && wait_left != 2'h0) begin
			// One wait cycle spent
			wait_left <= wait_left - 2'h1;
		end
	end

	// Array address: latched on take and held, so the array sees a stable
	// address for the whole access and the model's output can settle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			array_addr <= '0;
		end else if (take_rd) begin
			array_addr <= rd_addr;
		end
	end

	// Ready pulse: high for exactly one cycle after the last access cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_ready <= 1'b0;
		end else begin
			rd_ready <= end_rd;
		end
	end

	// Read data: captured at the edge that raises ready, then held until
	// the next completed read, so a late consumer still sees the word
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (end_rd) begin
			rd_data <= array_data;
		end
	end

	// Program/erase acceptance.
	// Program wins when both starts arrive together; starts while busy are
	// ignored, since the array cannot run two operations at once.
	always_comb begin
		take_prog = 1'b0;
		take_erase = 1'b0;
		end_pe = 1'b0;
		// Idle: take at most one start
		if (pe_state == flash_wait_pkg::PE_IDLE) begin
			take_prog = prog_start;
			take_erase = erase_start && !prog_start;
		end
		// Busy: the countdown reached its end
		if (pe_state != flash_wait_pkg::PE_IDLE && pe_count == 32'h0) begin
			end_pe = 1'b1;
		end
	end

	// Program/erase sequencer state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pe_state <= flash_wait_pkg::PE_IDLE;
		end else begin
			case (pe_state)
				// Waiting for a start
				flash_wait_pkg::PE_IDLE: begin
					if (take_prog) begin
						pe_state <= flash_wait_pkg::PE_PROG;
					end else if (take_erase) begin
						pe_state <= flash_wait_pkg::PE_ERASE;
					end
				end
				// Block program or sector erase running
				flash_wait_pkg::PE_PROG, flash_wait_pkg::PE_ERASE: begin
					if (end_pe) begin
						pe_state <= flash_wait_pkg::PE_IDLE;
					end
				end
				// Unused code: recover to idle
				default: begin
					pe_state <= flash_wait_pkg::PE_IDLE;
				end
			endcase
		end
	end

	// Busy countdown. The count is the worst-case time, not the typical
	// one, so software waiting on done never polls an unfinished array.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pe_count <= 32'h0;
		end else if (take_prog) begin
			// Block program time
			pe_count <= 32'(PROG_CYCLES - 1);
		end else if (take_erase) begin
			// Sector erase time
			pe_count <= 32'(ERASE_CYCLES - 1);
		end else if (pe_state != flash_wait_pkg::PE_IDLE && pe_count != 32'h0) begin
			// One cycle of the operation spent
			pe_count <= pe_count - 32'h1;
		end
	end

	// Busy level: rises on a start, falls with the done pulse
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pe_busy <= 1'b0;
		end else if (take_prog || take_erase) begin
			pe_busy <= 1'b1;
		end else if (end_pe) begin
			pe_busy <= 1'b0;
		end
	end

	// Done pulse: one cycle, at the edge where busy falls
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pe_done <= 1'b0;
		end else begin
			pe_done <= end_pe;
		end
	end

	// Limitations worth knowing:
	// - The wait count is a level input; software must keep it covering
	//   the array access time at the clock in use, nothing here checks it.
	// - Sequential fetches never miss the prefetch in this model, so they
	//   always finish in one access cycle regardless of the field.
	// - Program and erase only time the operation; the array contents are
	//   handled by the array itself.
	// - A read and a program or erase may overlap here; the fetch side is
	//   expected not to read the array while it is busy.
endmodule : flash_wait_state_access
